/* design/alc_regs.vh */
// register offsets, field positions, reset values and timing counts
`ifndef ALC_REGS_VH
`define ALC_REGS_VH
// word offsets (byte address = 4 * index)
`define CFG0_IDX        4'h0
`define CFG1_IDX        4'h1
`define CFG2_IDX        4'h2
`define STAT_IDX        4'h3
// cfg0 fields
`define C0_REC_EN       0
`define C0_PB_EN        1
`define C0_PATH         2
`define C0_FRN          3
`define C0_FAST_ATTEN_INTERVAL_SELECT        4
`define C0_EQDIS        5
`define C0_WAIT_LO      8
`define C0_STEP_LO      12
`define C0_FST_LO       16
`define C0_LMTH_LO      20
`define C0_EQF_LO       24
`define C0_KNEE_LO      28
// cfg1 fields
`define C1_IREF_LO      0
`define C1_OREF_LO      8
`define C1_SLOPE_LO     16
// reset values
`define CFG0_RST        32'h2200_0000
`define CFG1_RST        32'h0000_28E1
`define CFG2_RST        32'h0000_0000
// gain in 1/1024 dB units, level encodings
`define IREF_0DB        8'h91
`define OREF_0DB        6'h24
`define STEP_4          12'h004
`define STEP_2          12'h002
`define STEP_1          12'h001
`define FST_0           12'h003
`define FST_1           12'h004
`define FST_2           12'h007
`define FST_3           12'h00D
`define MUTE_GAIN       17'h1_B000
`define WAIT_BASE       11'h080
`define FATT_SLOW       6'h10
`define FATT_FAST       6'h04
`endif

/* design/sample_timer.v */
// wait timer for the recovery block, counted in fs ticks
`timescale 1ns/100ps
module sample_timer #(
  parameter W = 11
) (
  // clock and reset
  input  wire         clk,
  input  wire         nrst,
  // control
  input  wire         tick,
  input  wire         clr,
  input  wire [W-1:0] limit,
  // state
  output reg          done
);
  reg [W-1:0] cnt_r;
  // saturating count; done holds while clear is low
  always @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      cnt_r <= {W{1'b0}};
      done  <= 1'b0;
    end else if (clr) begin
      cnt_r <= {W{1'b0}};
      done  <= 1'b0;
    end else if (tick && !done) begin
      if (cnt_r == limit - 1'b1) begin
        done <= 1'b1;
      end
      cnt_r <= cnt_r + 1'b1;
    end
  end
endmodule

/* design/db_to_gain_code.v */
// gain in 1/1024 dB below +36 dB to 0.75 dB status code
`timescale 1ns/100ps
module db_to_gain_code (
  // input attenuation from +36 dB, 1/1024 dB units
  input  wire [16:0] atten,
  input  wire        muted,
  // status code
  output reg  [7:0]  code
);
  reg [16:0] band;
  // 0.75 dB = 768 units; a band includes its lower gain edge,
  // so an exact multiple of 768 belongs to the band above it
  always @* begin
    band = (atten == 17'h0_0000) ? 17'h0_0000
         : (atten - 17'd1) / 17'd768;
    if (muted) begin
      code = 8'h00;
    end else if (atten == 17'h0_0000) begin
      code = 8'hFF;
    end else if (band >= 17'd119) begin
      code = 8'h10;
    end else begin
      code = 8'hFE - {band[6:0], 1'b0};
    end
  end
endmodule

/* design/alc_recovery.v */
// level control recovery: timer, stepping, references, status
//
// The Avalon-MM interface to the registers and the register addresses were chosen for this implementation.
`timescale 1ns/100ps
`include "alc_regs.vh"
// Functional notes
// R1: clear wait timer when output sits between reset and limiter levels
// R2: wait timer runs while output stays below reset level
// R3: wait select gives 128, 256, 512 or 1024 samples
// R4: step select gives normal increment size and interval
// R5: fast recovery after impulse uses faster step sizes
// R6: fast steps apply only while fast disable bit is zero
// R7: fast recovery lowers reference 0.00106 dB every 4 or 16 samples; code lowers it 1/1024 dB per step
// R8: record reference 0.375 dB steps, 91H is 0 dB, E1H default
// R9: playback reference 1.5 dB steps, 24H is 0 dB, 28H default
// R10: live gain continuously readable with 0.75 dB resolution
// R11: status code FFH top, minus 2 per band, 10H floor, 00H mute
// R12: host changes settings only with both path enables cleared
// R13: after both enables clear, output zero until manual mode
// R14: knee point -33 dB down to -54 dB in 3 dB steps
// R15: slope beyond knee 1.0 to 1.5 in eighths
// R16: host alters knee point only while level control disabled
// R17: knee has no effect on playback or below 0 dB reference
// R18: slope leaving 1.0 jumps to second reference; back ramps slowly
// R19: path select picks record or playback; separate enables
// R20: after wait, step up at interval, stop at reference level
module alc_recovery (
  // clock and reset
  input  wire        clk,
  input  wire        nrst,
  // avalon-mm slave
  input  wire [3:0]  address,
  input  wire        read,
  input  wire        write,
  input  wire [31:0] writedata,
  input  wire [3:0]  byteenable,
  output reg  [31:0] readdata,
  output reg         waitrequest,
  // sample timing and level detection
  input  wire        fs_tick,
  input  wire        above_reset_lvl,
  input  wire        above_limit_lvl,
  input  wire        impulse_seen,
  input  wire        manual_ready,
  input  wire [7:0]  input_level_db,
  // gain output
  output reg  [16:0] gain_atten,
  output reg         gain_mute,
  output reg         zero_out
);
  localparam WTW = 11;
  localparam S_IDLE = 3'b001;
  localparam S_RUN  = 3'b010;
  localparam S_STOP = 3'b100;

  reg  [31:0] cfg0_r;
  reg  [31:0] cfg1_r;
  reg  [2:0]  state_r;
  reg  [2:0]  state_nxt;
  reg  [16:0] cur_r;
  reg  [16:0] fref_r;
  reg  [4:0]  ivl_cnt_r;
  reg  [5:0]  fatt_cnt_r;
  reg         fast_r;
  reg  [2:0]  slope_prev_r;
  reg  [7:0]  status_r;
  wire [7:0]  status_w;
  wire        wait_done;
  wire        run;
  wire [WTW-1:0] wait_lim;
  reg  [16:0] reference_below_knee;
  reg  [16:0] reference_above_knee;
  reg  [16:0] ref_sel;
  reg  [11:0] step;
  reg  [4:0]  ivl_lim;
  reg  [16:0] knee;
  reg  [16:0] below;
  reg  [19:0] slope_mul;

  // config fields
  wire        rec_en   = cfg0_r[`C0_REC_EN];
  wire        pb_en    = cfg0_r[`C0_PB_EN];
  wire        path_rec = cfg0_r[`C0_PATH];
  wire        fast_recovery_disable      = cfg0_r[`C0_FRN];
  wire        fast_atten_interval_select    = cfg0_r[`C0_FAST_ATTEN_INTERVAL_SELECT];
  wire [1:0]  wsel     = cfg0_r[`C0_WAIT_LO +: 2];
  wire [2:0]  rsel     = cfg0_r[`C0_STEP_LO +: 3];
  wire [1:0]  fsel     = cfg0_r[`C0_FST_LO +: 2];
  wire [2:0]  ksel     = cfg0_r[`C0_KNEE_LO +: 3];
  wire [7:0]  iref     = cfg1_r[`C1_IREF_LO +: 8];
  wire [5:0]  oref     = cfg1_r[`C1_OREF_LO +: 6];
  wire [2:0]  slope    = cfg1_r[`C1_SLOPE_LO +: 3];
  wire        act_en   = path_rec ? rec_en : pb_en;  // [R19]

  assign run = (state_r == S_RUN);
  assign wait_lim = {{(WTW-11){1'b0}}, `WAIT_BASE} << wsel;  // [R3]

  // single-cycle slave: waitrequest drops the cycle after a request
  always @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      waitrequest <= 1'b1;
      readdata    <= 32'h0000_0000;
      cfg0_r      <= `CFG0_RST;
      cfg1_r      <= `CFG1_RST;
    end else begin
      waitrequest <= 1'b1;
      if ((read || write) && waitrequest) begin
        waitrequest <= 1'b0;
      end
      if (read && waitrequest) begin
        case (address)
          `CFG0_IDX: readdata <= cfg0_r;
          `CFG1_IDX: readdata <= cfg1_r;
          `STAT_IDX: readdata <= {21'h0_0000, fast_r, run,
                                  status_r};  // [R10]
          default:   readdata <= 32'h0000_0000;
        endcase
      end
      // writes land on the edge where waitrequest is seen low; settings
      // are the host's to keep steady while enables are set
      if (write && !waitrequest && address == `CFG0_IDX) begin  // [R12]
        if (byteenable[0]) cfg0_r[7:0]   <= writedata[7:0];
        if (byteenable[1]) cfg0_r[15:8]  <= writedata[15:8];
        if (byteenable[2]) cfg0_r[23:16] <= writedata[23:16];
        if (byteenable[3]) cfg0_r[31:24] <= writedata[31:24];  // [R16]
      end
      if (write && !waitrequest && address == `CFG1_IDX) begin
        if (byteenable[0]) cfg1_r[7:0]   <= writedata[7:0];
        if (byteenable[1]) cfg1_r[15:8]  <= writedata[15:8];
        if (byteenable[2]) cfg1_r[23:16] <= writedata[23:16];
      end
    end
  end

  // references in 1/1024 dB attenuation below +36 dB
  always @* begin
    // 0.375 dB = 384 units, 1.5 dB = 1536 units
    reference_below_knee = (iref < 8'h05) ? `MUTE_GAIN
         : (17'd384 * {9'h000, 8'hF1 - iref});  // [R8]
    if (!path_rec) begin
      reference_below_knee = (oref == 6'h00) ? `MUTE_GAIN
           : (17'd1536 * {11'h000, 6'h3C - oref});  // [R9]
    end
    // knee at -33 dB - 3 dB*code: 69 dB + 3*code below +36
    knee = 17'd70656 + 17'd3072 * {14'h0000, ksel};  // [R14]
    below = (input_level_db[6:0] * 17'd1024 > knee) ?
            (input_level_db[6:0] * 17'd1024 - knee) : 17'h0_0000;
    // slope in eighths: extra reduction past the knee
    slope_mul = {3'b000, below} * {17'h0_0000, slope};  // [R15]
    reference_above_knee = reference_below_knee + slope_mul[19:3];
    if (slope > 3'b100) begin
      reference_above_knee = reference_below_knee;
    end
    // no knee on playback or a reference under 0 dB
    if (!path_rec || iref < `IREF_0DB || slope == 3'b000) begin
      reference_above_knee = reference_below_knee;  // [R17]
    end
    ref_sel = reference_above_knee;
  end

  // step size and interval
  always @* begin
    case (rsel)
      3'b000:  step = `STEP_4;  // [R4]
      3'b001:  step = `STEP_2;
      default: step = `STEP_1;
    endcase
    ivl_lim = (rsel < 3'b011) ? 5'd0 : (5'd1 << (rsel - 3'd2)) - 5'd1;
    if (fast_r && !fast_recovery_disable) begin  // [R6]
      case (fsel)
        2'b00:   step = `FST_0;  // [R5]
        2'b01:   step = `FST_1;
        2'b10:   step = `FST_2;
        default: step = `FST_3;
      endcase
      ivl_lim = 5'd0;
    end
  end

  // wait timer: cleared in the reset band or while not running
  sample_timer #(.W(WTW)) wait_tmr (
    .clk   (clk),
    .nrst  (nrst),
    .tick  (fs_tick && !above_reset_lvl),  // [R2]
    .clr   (!run || (above_reset_lvl && !above_limit_lvl)),  // [R1]
    .limit (wait_lim),
    .done  (wait_done)
  );

  db_to_gain_code conv (
    .atten (cur_r),
    .muted (cur_r >= `MUTE_GAIN),
    .code  (status_w)
  );

  // run / stop sequencing
  always @* begin
    case (state_r)
      S_IDLE:  state_nxt = act_en ? S_RUN : S_IDLE;
      S_RUN:   state_nxt = (!rec_en && !pb_en) ? S_STOP : S_RUN;
      S_STOP:  state_nxt = manual_ready ? S_IDLE : S_STOP;
      default: state_nxt = S_IDLE;
    endcase
  end

  // gain tracking; a smaller attenuation means more gain
  always @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      state_r      <= S_IDLE;
      cur_r        <= 17'd2304;
      fref_r       <= 17'h0_0000;
      ivl_cnt_r    <= 5'd0;
      fatt_cnt_r   <= 6'd0;
      fast_r       <= 1'b0;
      slope_prev_r <= 3'b000;
      status_r     <= 8'h00;
      gain_atten   <= 17'h0_0000;
      gain_mute    <= 1'b0;
      zero_out     <= 1'b0;
    end else begin
      state_r      <= state_nxt;
      slope_prev_r <= slope;
      status_r     <= status_w;  // [R11]
      gain_atten   <= cur_r;
      gain_mute    <= cur_r >= `MUTE_GAIN;
      zero_out     <= (state_r == S_STOP);  // [R13]
      if (impulse_seen && run && !fast_recovery_disable) begin
        fast_r <= 1'b1;
        fref_r <= 17'h0_0000;
      end
      if (run && slope_prev_r == 3'b000 && slope != 3'b000) begin
        cur_r <= ref_sel;  // [R18]
      end else if (run && fs_tick && wait_done) begin
        if (ivl_cnt_r >= ivl_lim) begin
          ivl_cnt_r <= 5'd0;
          if (cur_r > ref_sel + fref_r + {5'h00, step}) begin
            cur_r <= cur_r - {5'h00, step};  // [R20]
          end else begin
            cur_r  <= ref_sel + fref_r;
            fast_r <= 1'b0;
          end
        end else begin
          ivl_cnt_r <= ivl_cnt_r + 5'd1;
        end
        // fast recovery pulls its reference down step by step
        if (fast_r) begin
          if (fatt_cnt_r >= (fast_atten_interval_select ? `FATT_SLOW : `FATT_FAST) - 6'd1)
          begin
            fatt_cnt_r <= 6'd0;
            fref_r     <= fref_r + 17'd1;  // [R7]
          end else begin
            fatt_cnt_r <= fatt_cnt_r + 6'd1;
          end
        end
      end
    end
  end
endmodule

/* tb/alc_recovery_chk.sv */
// port checker for the level control recovery block
`timescale 1ns/100ps
module alc_recovery_chk (
  // clock and reset
  input wire        clk,
  input wire        nrst,
  // register bus
  input wire [3:0]  address,
  input wire        read,
  input wire        write,
  input wire [31:0] writedata,
  input wire [3:0]  byteenable,
  input wire [31:0] readdata,
  input wire        waitrequest,
  // levels and gain
  input wire        above_reset_lvl,
  input wire        above_limit_lvl,
  input wire        manual_ready,
  input wire [16:0] gain_atten,
  input wire        zero_out
);
  reg [1:0] en_r;
  reg       sl_r;
  default clocking @(posedge clk); endclocking
  default disable iff (!nrst);
  // track path enables; a slope write may jump the gain, so it exempts
  always @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      en_r <= 2'h0;
      sl_r <= 1'h0;
    end else if (!waitrequest && write) begin
      if (address == 4'h0 && byteenable[0])
        en_r <= writedata[1:0];
      if (address == 4'h1 && byteenable[2])
        sl_r <= 1'h1;
    end
  end
  // bus handshake
  property p_take; (read || write) && waitrequest |=> !waitrequest; endproperty
  a_take: assert property (p_take) else $error("request not answered");
  property p_one; !waitrequest |=> waitrequest; endproperty
  a_one: assert property (p_one) else $error("answer held too long");
  property p_idle; !read && !write && waitrequest |=> waitrequest; endproperty
  a_idle: assert property (p_idle) else $error("answer without request");
  property p_unmap; read && waitrequest && address > 4'h3 |=> readdata == 32'h0;
  endproperty
  a_unmap: assert property (p_unmap) else $error("unmapped read not zero");
  // zero output after both enables clear
  property p_zero; !waitrequest && write && address == 4'h0 && byteenable[0]
    && writedata[1:0] == 2'h0 && en_r != 2'h0 && !manual_ready
    |-> ##[1:3] zero_out; endproperty
  a_zero: assert property (p_zero) else $error("no zero output");
  property p_zhold; zero_out && en_r == 2'h0 && !manual_ready && !write
    |=> zero_out; endproperty
  a_zhold: assert property (p_zhold) else $error("zero output lost");
  // gain rise per cycle never beyond the largest fast step
  property p_stepmax; gain_atten < $past(gain_atten) && !sl_r
    |-> $past(gain_atten) - gain_atten <= 17'h0000D; endproperty
  a_stepmax: assert property (p_stepmax) else $error("gain step too big");
  property p_band; (above_reset_lvl && !above_limit_lvl)[*3]
    |=> gain_atten >= $past(gain_atten); endproperty
  a_band: assert property (p_band) else $error("gain rose in band");
endmodule
bind alc_recovery alc_recovery_chk alc_recovery_chk_i (.clk, .nrst, .address,
  .read, .write, .writedata, .byteenable, .readdata, .waitrequest,
  .above_reset_lvl, .above_limit_lvl, .manual_ready, .gain_atten, .zero_out);

/* tb/alc_recovery_tb.sv */
// bench for the level control recovery block
`timescale 1ns/100ps
`include "alc_regs.vh"
module alc_recovery_tb;
  reg         clk = 1'h0;
  reg         nrst = 1'h0;
  reg  [3:0]  address = 4'h0;
  reg         read = 1'h0;
  reg         write = 1'h0;
  reg  [31:0] writedata = 32'h0;
  reg  [3:0]  byteenable = 4'hF;
  reg         fs_tick = 1'h0;
  reg         above_reset_lvl = 1'h0;
  reg         above_limit_lvl = 1'h0;
  reg         impulse_seen = 1'h0;
  reg         manual_ready = 1'h0;
  reg  [7:0]  level_db = 8'h00;
  wire [31:0] readdata;
  wire        waitrequest;
  wire [16:0] gain_atten;
  wire        zero_out;
  integer     err_total = 0;
  integer     compares = 0;
  integer     i;
  integer     d;
  reg  [31:0] rd;
  reg  [16:0] g0;
  // 20 MHz clock
  always #25 clk = ~clk;
  alc_recovery alc_recovery_i (.clk(clk), .nrst(nrst), .address(address),
    .read(read), .write(write), .writedata(writedata),
    .byteenable(byteenable), .readdata(readdata), .waitrequest(waitrequest),
    .fs_tick(fs_tick), .above_reset_lvl(above_reset_lvl),
    .above_limit_lvl(above_limit_lvl), .impulse_seen(impulse_seen),
    .manual_ready(manual_ready), .input_level_db(level_db),
    .gain_atten(gain_atten), .gain_mute(), .zero_out(zero_out));
  task chk(input [31:0] seen, input [31:0] exp);
    begin
      compares = compares + 1;
      if (seen !== exp) begin
        err_total = err_total + 1;
        $display("mismatch at %0t: saw %h expected %h", $time, seen, exp);
      end
    end
  endtask
  task give_verdict;
    begin
      $display("compares %0d err_total %0d", compares, err_total);
      if (err_total == 0 && compares > 0)
        $display("Testbench passed");
      else
        $display("Testbench failed");
      $finish;
    end
  endtask
  // one transfer, request held until waitrequest is sampled low
  task bus(input w, input [3:0] a, input [31:0] wd, input [3:0] be);
    integer n;
    begin
      @(posedge clk);
      read <= !w;
      write <= w;
      address <= a;
      writedata <= wd;
      byteenable <= be;
      n = 0;
      // look between edges so the sampled level is settled
      @(negedge clk);
      while (waitrequest && n < 20) begin
        n = n + 1;
        @(negedge clk);
      end
      @(posedge clk);
      rd = readdata;
      read <= 1'h0;
      write <= 1'h0;
      if (n == 20) begin
        chk(32'h0, 32'h1);
        give_verdict;
      end
    end
  endtask
  // one sample every four clocks
  task ticks(input integer k);
    repeat (k) begin
      @(posedge clk);
      fs_tick <= 1'h1;
      @(posedge clk);
      fs_tick <= 1'h0;
      repeat (2) @(posedge clk);
    end
  endtask
  task wait_zero(input v);
    integer n;
    begin
      n = 0;
      while (zero_out !== v && n < 50) begin
        @(posedge clk);
        n = n + 1;
      end
      chk({31'h0, zero_out}, {31'h0, v});
      if (n == 50)
        give_verdict;
    end
  endtask
  // fresh reset, reference at top, settings written while disabled
  task start(input f, input [1:0] wc, input [2:0] sc, input [1:0] fc);
    reg [31:0] c;
    begin
      c = `CFG0_RST | (f << `C0_FRN) | (wc << `C0_WAIT_LO)
        | (sc << `C0_STEP_LO) | (fc << `C0_FST_LO) | 32'h4;
      @(posedge clk);
      nrst <= 1'h0;
      repeat (6) @(posedge clk);
      nrst <= 1'h1;
      bus(1'h1, `CFG1_IDX, 32'h0000_28F1, 4'hF);
      bus(1'h1, `CFG0_IDX, c, 4'hF);
      bus(1'h1, `CFG0_IDX, c | 32'h1, 4'hF);
      g0 = gain_atten;
    end
  endtask
  // wait period then stepping at the selected size and interval
  task t_wait(input [1:0] wc, input integer n, input [2:0] sc,
              input integer u, input integer iv);
    begin
      start(1'h1, wc, sc, 2'h0);
      ticks(n - 2);
      chk({15'h0, gain_atten}, {15'h0, g0});
      ticks(96);
      d = g0 - gain_atten;
      chk({31'h0, d >= u * (96 / iv - 2) && d <= u * (96 / iv + 2)}, 1);
    end
  endtask
  initial begin
    repeat (6) @(posedge clk);
    nrst <= 1'h1;
    // reset values, byte lanes, unmapped place
    bus(1'h0, `CFG0_IDX, 32'h0, 4'hF);
    chk(rd, 32'h2200_0000);
    bus(1'h0, `CFG1_IDX, 32'h0, 4'hF);
    chk(rd, 32'h0000_28E1);
    bus(1'h0, `STAT_IDX, 32'h0, 4'hF);
    chk({24'h0, rd[7:0]}, 32'h0000_00FA);
    bus(1'h1, 4'h5, 32'hFFFF_FFFF, 4'hF);
    bus(1'h0, 4'h5, 32'h0, 4'hF);
    chk(rd, 32'h0);
    bus(1'h1, `CFG1_IDX, 32'hFFFF_FF05, 4'h1);
    bus(1'h0, `CFG1_IDX, 32'h0, 4'hF);
    chk(rd, 32'h0000_2805);
    // every wait code and step code
    t_wait(2'h0, 128, 3'h0, 4, 1);
    t_wait(2'h1, 256, 3'h1, 2, 1);
    t_wait(2'h2, 512, 3'h2, 1, 1);
    t_wait(2'h3, 1024, 3'h7, 1, 32);
    for (i = 3; i < 7; i = i + 1)
      t_wait(2'h0, 128, i[2:0], 1, 1 << (i - 2));
    // timer held clear in band, runs again below it
    start(1'h1, 2'h0, 3'h0, 2'h0);
    above_reset_lvl <= 1'h1;
    ticks(300);
    chk({15'h0, gain_atten}, {15'h0, g0});
    above_reset_lvl <= 1'h0;
    ticks(126);
    chk({15'h0, gain_atten}, {15'h0, g0});
    ticks(20);
    chk({31'h0, gain_atten < g0}, 1);
    // slope 1.125 with input 21 dB past a -39 dB knee: 2.625 dB lower
    start(1'h1, 2'h0, 3'h0, 2'h0);
    level_db <= 8'h60;
    bus(1'h1, `CFG1_IDX, 32'h0001_28F1, 4'hF);
    repeat (4) @(posedge clk);
    chk({15'h0, gain_atten}, {15'h0, 17'd2688});
    level_db <= 8'h00;
    // fast recovery outruns the same run with fast mode disabled
    start(1'h0, 2'h0, 3'h7, 2'h3);
    impulse_seen <= 1'h1;
    ticks(224);
    impulse_seen <= 1'h0;
    d = g0 - gain_atten;
    start(1'h1, 2'h0, 3'h7, 2'h3);
    impulse_seen <= 1'h1;
    ticks(224);
    impulse_seen <= 1'h0;
    chk({31'h0, d > g0 - gain_atten}, 1);
    // zero samples until manual mode takes over
    bus(1'h1, `CFG0_IDX, `CFG0_RST | 32'h4, 4'hF);
    wait_zero(1'h1);
    repeat (10) @(posedge clk);
    chk({31'h0, zero_out}, 1);
    manual_ready <= 1'h1;
    wait_zero(1'h0);
    give_verdict;
  end
endmodule
